// ==== include/pei_pkg.sv ====
// Constants for the PHY extended control and interrupt register block.
// Assumes APB access with one aligned 32-bit word per register index.
package pei_pkg;

   localparam int unsigned      ADDR_W        = 8;
   localparam int unsigned      REG_W         = 16;
   localparam int unsigned      SRC_N         = 15;

   // Register indices as printed; byte address is four times the index
   localparam logic [7:0]       IDX_CTL1      = 8'h17;
   localparam logic [7:0]       IDX_CTL2      = 8'h18;
   localparam logic [7:0]       IDX_MASK      = 8'h19;
   localparam logic [7:0]       IDX_STAT      = 8'h1A;
   localparam logic [ADDR_W-1:0] ADDR_CTL1    = 8'({IDX_CTL1, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_CTL2    = 8'({IDX_CTL2, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_MASK    = 8'({IDX_MASK, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_STAT    = 8'({IDX_STAT, 2'b00});

   // Field positions
   localparam int unsigned      POS_FAR_LOOP  = 3;
   localparam int unsigned      POS_EDGE_LO   = 13;
   localparam int unsigned      POS_FIFO_LO   = 4;
   localparam int unsigned      POS_CBL_LOOP  = 0;
   localparam int unsigned      POS_GLB_EN    = 15;
   localparam int unsigned      POS_SUMMARY   = 15;
   localparam int unsigned      POS_RSVD_SRC  = 6;

   // Writable bits of the mask register and the source bits of status
   localparam logic [15:0]      MASK_WR_BITS  = 16'hFFBF;
   localparam logic [14:0]      SRC_BITS      = 15'h7FBF;

   // Reset values
   localparam logic             RST_FAR_LOOP  = 1'b0;
   localparam logic             RST_CBL_LOOP  = 1'b0;
   localparam logic [2:0]       RST_EDGE      = 3'h0;
   localparam logic [1:0]       RST_FIFO      = 2'h0;
   localparam logic [15:0]      RST_MASK      = 16'h0000;

   typedef enum logic [1:0] {
      PEI_FIFO_STD   = 2'b00,
      PEI_FIFO_9K    = 2'b01,
      PEI_FIFO_12K   = 2'b10,
      PEI_FIFO_RSVD  = 2'b11
   } pei_fifo_t;

   localparam logic [13:0]      LEN_STD       = 14'd1518;
   localparam logic [13:0]      LEN_9K        = 14'd9000;
   localparam logic [13:0]      LEN_12K       = 14'd12000;

   function automatic logic [13:0] fifo_bytes(input logic [1:0] sel);
      unique case (pei_fifo_t'(sel))
         PEI_FIFO_9K  : fifo_bytes = LEN_9K;
         PEI_FIFO_12K : fifo_bytes = LEN_12K;
         default      : fifo_bytes = LEN_STD;
      endcase
   endfunction

endpackage

// ==== design/pei_apb_slave.sv ====
// APB handshake for the register block: one wait state, then completion.
// Assumes an APB master that holds the request until pready is seen.
`timescale 1ns/100ps
module pei_apb_slave (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic psel,
   input  wire logic penable,
   input  wire logic pwrite,
   output logic      pready,
   output logic      load_rd,
   output logic      wr_done,
   output logic      rd_done
);
   logic pready_ff;
   logic nxt_pready;

   // Access phase lasts two cycles so read data can be registered
   assign nxt_pready = psel & penable & ~pready_ff;
   assign load_rd    = nxt_pready;
   assign pready     = pready_ff;
   assign wr_done    = psel & penable & pready_ff & pwrite;
   assign rd_done    = psel & penable & pready_ff & ~pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= nxt_pready;
      end
   end
endmodule // pei_apb_slave

// ==== design/pei_pend_bank.sv ====
// Pending interrupt conditions, one per source, with read and write clears.
// Assumes source events are one-cycle pulses synchronous to pclk.
`timescale 1ns/100ps
module pei_pend_bank #(
   parameter int unsigned N = 15
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [N-1:0] evt,
   input  wire logic [N-1:0] clr,
   output logic [N-1:0]      pend
);
   logic [N-1:0] pend_ff;
   logic [N-1:0] nxt_pend;

   // A new event in the clearing cycle survives
   assign nxt_pend = evt | (pend_ff & ~clr);
   assign pend     = pend_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_ff <= '0;
      end else begin
         pend_ff <= nxt_pend;
      end
   end
endmodule // pei_pend_bank

// ==== design/pei_top.sv ====
// PHY extended control, loopback, edge rate, FIFO length and interrupts.
// Assumes APB master on pclk and source pulses synchronous to pclk.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps

// Functional notes
// - Control one index 23: bit 3 far-end loopback R/W, reset 0, rest reserved.
// - Control two bits 15:13 select 100BASE-TX edge rate, all eight codes.
// - Control two bits 5:4 select FIFO length 1518/9000/12000, code 11 reserved.
// - Control two bit 0 cable loopback R/W reset 0; 12:6 and 3:1 reserved.
// - Mask bit 15 global enable gates interrupt pin and summary status bit.
// - Mask holds one R/W enable per source, reset 0, bit 6 reserved.
// - Status index 26 mirrors mask layout, bit 6 reserved, bit 15 summary.
// - Status bit never shows while mask clear; condition still held pending.
// - Setting a mask bit reveals an already pending condition in status.
// - Status read clears only conditions whose mask bit is set at the read.
module pei_top #(
   parameter int unsigned AW = pei_pkg::ADDR_W
) (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [AW-1:0]            paddr,
   input  wire logic [31:0]              pwdata,
   input  wire logic [3:0]               pstrb,
   output logic [31:0]                   prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic [pei_pkg::SRC_N-1:0] src_evt,
   output logic                          far_loop_en,
   output logic                          cable_loop_en,
   output logic [2:0]                    edge_rate,
   output logic [1:0]                    fifo_len_sel,
   output logic [13:0]                   max_pkt_bytes,
   output logic                          irq
);

   localparam int unsigned SN = pei_pkg::SRC_N;

   // Bus handshake
   logic                load_rd;
   logic                wr_done;
   logic                rd_done;
   logic [31:0]         prdata_ff;
   logic                pslverr_ff;

   pei_apb_slave u_apb (
      .pclk    (pclk),
      .presetn (presetn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .pready  (pready),
      .load_rd (load_rd),
      .wr_done (wr_done),
      .rd_done (rd_done)
   );

   // Address decode
   logic                hit_ctl1;
   logic                hit_ctl2;
   logic                hit_mask;
   logic                hit_stat;
   logic                hit_any;
   logic [1:0]          lanes_lo;

   assign hit_ctl1 = (paddr == pei_pkg::ADDR_CTL1);
   assign hit_ctl2 = (paddr == pei_pkg::ADDR_CTL2);
   assign hit_mask = (paddr == pei_pkg::ADDR_MASK);
   assign hit_stat = (paddr == pei_pkg::ADDR_STAT);
   assign hit_any  = hit_ctl1 | hit_ctl2 | hit_mask | hit_stat;
   assign lanes_lo = pstrb[1:0];

   // Registers are 16 bits wide: only a write with both low lanes counts,
   // so a half-written field can never steer the PHY.
   logic                wr_ok;
   logic                wr_ctl1;
   logic                wr_ctl2;
   logic                wr_mask;
   logic                wr_stat;

   assign wr_ok   = wr_done & (lanes_lo == 2'b11);
   assign wr_ctl1 = wr_ok & hit_ctl1;
   assign wr_ctl2 = wr_ok & hit_ctl2;
   assign wr_mask = wr_ok & hit_mask;
   assign wr_stat = wr_ok & hit_stat;

   // Control one
   logic                far_loop_ff;
   logic                nxt_far_loop;

   assign nxt_far_loop = wr_ctl1 ? pwdata[pei_pkg::POS_FAR_LOOP] : far_loop_ff;

   // Control two
   logic [2:0]          edge_ff;
   logic [2:0]          nxt_edge;
   logic [1:0]          fifo_ff;
   logic [1:0]          nxt_fifo;
   logic                cbl_loop_ff;
   logic                nxt_cbl_loop;
   logic [1:0]          wr_fifo_code;
   logic                fifo_code_ok;
   logic [13:0]         len_ff;
   logic [13:0]         nxt_len;

   assign nxt_edge     = wr_ctl2 ? pwdata[pei_pkg::POS_EDGE_LO +: 3] : edge_ff;
   assign wr_fifo_code = pwdata[pei_pkg::POS_FIFO_LO +: 2];
   // The reserved length code is dropped and the old length kept
   assign fifo_code_ok = (wr_fifo_code != pei_pkg::PEI_FIFO_RSVD);
   assign nxt_fifo     = (wr_ctl2 && fifo_code_ok) ? wr_fifo_code : fifo_ff;
   assign nxt_len      = pei_pkg::fifo_bytes(nxt_fifo);
   assign nxt_cbl_loop = wr_ctl2 ? pwdata[pei_pkg::POS_CBL_LOOP] : cbl_loop_ff;

   // Mask register
   logic [15:0]         mask_ff;
   logic [15:0]         nxt_mask;
   logic                glb_en;
   logic [SN-1:0]       src_mask;

   assign nxt_mask = wr_mask ? (pwdata[15:0] & pei_pkg::MASK_WR_BITS) : mask_ff;
   assign glb_en   = mask_ff[pei_pkg::POS_GLB_EN];
   assign src_mask = mask_ff[SN-1:0];

   // Pending conditions and visible status
   logic [SN-1:0]       evt_in;
   logic [SN-1:0]       pend;
   logic [SN-1:0]       rd_clr;
   logic [SN-1:0]       w1c_clr;
   logic [SN-1:0]       pend_clr;
   logic [SN-1:0]       stat_vis;
   logic                summary;
   logic [15:0]         stat_word;

   assign evt_in   = src_evt & pei_pkg::SRC_BITS;
   // Only sources unmasked at the read lose their condition, and only those
   // already captured in the read data: an event landing between the capture
   // and the completing edge stays pending instead of vanishing unseen.
   assign rd_clr   = (rd_done & hit_stat) ? (prdata_ff[SN-1:0] & src_mask) : '0;
   assign w1c_clr  = wr_stat ? (pwdata[SN-1:0] & src_mask) : '0;
   assign pend_clr = rd_clr | w1c_clr;

   pei_pend_bank #(
      .N (SN)
   ) u_pend (
      .pclk    (pclk),
      .presetn (presetn),
      .evt     (evt_in),
      .clr     (pend_clr),
      .pend    (pend)
   );

   // Pending but masked conditions stay hidden; setting the mask shows them
   assign stat_vis  = pend & src_mask;
   assign summary   = glb_en & (|stat_vis);
   assign stat_word = {summary, stat_vis};

   // Read mux; reserved bits fall out as zero
   logic [15:0]         rd_word;
   logic [31:0]         nxt_prdata;
   logic                nxt_slverr;

   assign rd_word = hit_ctl1 ? (16'h0000 | (16'(far_loop_ff) << pei_pkg::POS_FAR_LOOP))
                  : hit_ctl2 ? {edge_ff, 7'h00, fifo_ff, 3'h0, cbl_loop_ff}
                  : hit_mask ? mask_ff
                  : hit_stat ? stat_word
                  : 16'h0000;
   assign nxt_prdata = (load_rd && !pwrite) ? {16'h0000, rd_word} : prdata_ff;
   assign nxt_slverr = load_rd ? ~hit_any : pslverr_ff;

   // Interrupt pin follows the summary with one register stage
   logic                irq_ff;
   logic                nxt_irq;

   assign nxt_irq = summary;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         far_loop_ff <= pei_pkg::RST_FAR_LOOP;
         edge_ff     <= pei_pkg::RST_EDGE;
         fifo_ff     <= pei_pkg::RST_FIFO;
         cbl_loop_ff <= pei_pkg::RST_CBL_LOOP;
         len_ff      <= pei_pkg::LEN_STD;
         mask_ff     <= pei_pkg::RST_MASK;
      end else begin
         far_loop_ff <= nxt_far_loop;
         edge_ff     <= nxt_edge;
         fifo_ff     <= nxt_fifo;
         cbl_loop_ff <= nxt_cbl_loop;
         len_ff      <= nxt_len;
         mask_ff     <= nxt_mask;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
         irq_ff     <= 1'b0;
      end else begin
         prdata_ff  <= nxt_prdata;
         pslverr_ff <= nxt_slverr;
         irq_ff     <= nxt_irq;
      end
   end

   assign prdata        = prdata_ff;
   assign pslverr       = pslverr_ff;
   assign far_loop_en   = far_loop_ff;
   assign cable_loop_en = cbl_loop_ff;
   assign edge_rate     = edge_ff;
   assign fifo_len_sel  = fifo_ff;
   assign max_pkt_bytes = len_ff;
   assign irq           = irq_ff;

   // Checks

   logic                rd_ctl1_done;
   logic                rd_stat_done;
   logic                rd_ctl2_done;
   logic                rd_mask_done;

   assign rd_ctl1_done = rd_done & hit_ctl1;
   assign rd_stat_done = rd_done & hit_stat;
   assign rd_ctl2_done = rd_done & hit_ctl2;
   assign rd_mask_done = rd_done & hit_mask;

   a_ctl1_reserved_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_ctl1_done |-> (prdata[15:0] == {12'h000, far_loop_en, 3'h0}))
      else $error("control one read shows reserved bits");

   a_edge_rate_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_ctl2 |=> (edge_rate == $past(pwdata[15:13])))
      else $error("edge rate not taken from write");

   a_fifo_rsvd_ignored: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_ctl2 && pwdata[5:4] == 2'b11) |=> $stable(fifo_len_sel) ##1
         (max_pkt_bytes == pei_pkg::fifo_bytes(fifo_len_sel)))
      else $error("reserved fifo code changed length");

   a_cable_loop_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_ctl2 |=> (cable_loop_en == $past(pwdata[0])))
      else $error("cable loopback not taken from write");

   a_glb_en_gates: assert property (
      @(posedge pclk) disable iff (!presetn)
      !glb_en |=> !irq)
      else $error("interrupt pin high with global enable clear");

   a_mask_rsvd_bit: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_mask |=> (mask_ff == ($past(pwdata[15:0]) & 16'hFFBF)))
      else $error("mask write wrong or reserved bit set");

   a_stat_layout: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_stat_done |-> (prdata[6] == 1'b0) && (prdata[31:16] == 16'h0000))
      else $error("status read shows reserved bits");

   a_stat_masked: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_stat_done |-> ((prdata[14:0] & ~$past(mask_ff[14:0])) == 15'h0000))
      else $error("status bit shown while mask clear");

   sequence s_pend_shown;
      glb_en && (|(pend & src_mask));
   endsequence

   a_pend_reveal: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_pend_shown |=> irq)
      else $error("unmasked pending condition not reflected");

   sequence s_stat_read;
      rd_stat_done;
   endsequence

   a_read_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_stat_read |=> ((pend & $past(prdata[SN-1:0]) & ~$past(evt_in)) == '0) &&
         (($past(pend & ~src_mask) & ~pend) == '0))
      else $error("status read cleared wrong conditions");

   a_irq_drops: assert property (
      @(posedge pclk) disable iff (!presetn)
      (stat_vis == '0) |=> !irq)
      else $error("interrupt pin held without unmasked status");

   a_far_loop_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_ctl1 |=> (far_loop_en == $past(pwdata[pei_pkg::POS_FAR_LOOP])))
      else $error("far-end loopback not taken from write");

   a_ctl2_reserved_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_ctl2_done |-> (prdata[12:6] == 7'h00) && (prdata[3:1] == 3'h0))
      else $error("control two read shows reserved bits");

   a_fifo_code_legal: assert property (
      @(posedge pclk) disable iff (!presetn)
      (fifo_len_sel != pei_pkg::PEI_FIFO_RSVD) &&
         (max_pkt_bytes == pei_pkg::fifo_bytes(fifo_len_sel)))
      else $error("fifo length code reserved or length mismatched");

   a_mask_read_back: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_mask_done |-> (prdata[15:0] == mask_ff) && !prdata[pei_pkg::POS_RSVD_SRC])
      else $error("mask read differs from mask or shows reserved bit");

   sequence s_evt_seen;
      |evt_in;
   endsequence

   a_evt_latched: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_evt_seen |=> (($past(evt_in) & ~pend) == '0))
      else $error("source event not latched as pending");

   a_w1c_masked_only: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_stat |=> (($past(pend & ~src_mask) & ~pend) == '0))
      else $error("status write cleared a masked-out condition");

   a_stat_summary: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_stat_done |-> (prdata[14:0] == $past(pend & src_mask)) &&
         (prdata[15] == ($past(glb_en) && (|prdata[14:0]))))
      else $error("status read value or summary bit wrong");

   a_rsvd_src_idle: assert property (
      @(posedge pclk) disable iff (!presetn)
      !pend[pei_pkg::POS_RSVD_SRC] && !mask_ff[pei_pkg::POS_RSVD_SRC])
      else $error("reserved interrupt source became active");

   // A mask write with the enable set must expose what was already pending
   sequence s_mask_opens;
      wr_mask && pwdata[pei_pkg::POS_GLB_EN] && (|(pend & pwdata[SN-1:0]));
   endsequence

   a_mask_reveals: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_mask_opens |=> (|stat_vis) ##1 irq)
      else $error("pending condition not revealed by mask write");

endmodule // pei_top

// ==== sim/pei_mgmt_model.sv ====
// Management-side model: an APB master that reaches the PHY register block.
// Assumes pclk comes from the bench; waits on pready without a limit of its own.
`timescale 1ns/100ps
module pei_mgmt_model (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
      pstrb   = 4'h0;
   end

   task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                       input logic [3:0] s, output logic [31:0] rdv, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {16'h0000, d};
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Released data lines must not keep looking valid
      pwdata  <= ~pwdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      wr_strb(a, d, 4'hF);
   endtask

   // Partial strobes let a test show that half-written words are dropped
   task automatic wr_strb(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
      logic [31:0] rdv;
      logic        err;
      xfer(1'b1, a, d, s, rdv, err);
   endtask

   // Reads drive no strobes
   task automatic rd(input logic [7:0] a, output logic [31:0] rdv, output logic err);
      xfer(1'b0, a, 16'h0000, 4'h0, rdv, err);
   endtask

   // Three-step enable keeps stale conditions off the pin
   task automatic enable_irq(input logic [15:0] m, output logic [31:0] flushed);
      logic err;
      wr(pei_pkg::ADDR_MASK, m & 16'h7FFF);
      rd(pei_pkg::ADDR_STAT, flushed, err);
      wr(pei_pkg::ADDR_MASK, m | 16'h8000);
   endtask
endmodule // pei_mgmt_model

// ==== sim/phy_ext_ctrl_interrupt_bench.sv ====
// Self-checking bench for the extended control and interrupt registers.
// Assumes the management model as APB master and pulses on src_evt.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_compared++; if ((exp) !== (got)) begin fails++; \
   $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module phy_ext_ctrl_interrupt_bench;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, irq;
   logic        far_loop_en, cable_loop_en, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic [14:0] src_evt = 15'h0000;
   logic [14:0] pend = 15'h0000;
   logic [15:0] mask = 16'h0000;
   logic [15:0] d;
   logic [1:0]  fsel = 2'h0;
   logic [2:0]  edge_rate;
   logic [1:0]  fifo_len_sel;
   logic [13:0] max_pkt_bytes;
   int          fails = 0;
   int          n_compared = 0;
   int          cycles = 0;

   pei_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .src_evt(src_evt), .far_loop_en(far_loop_en),
      .cable_loop_en(cable_loop_en), .edge_rate(edge_rate), .fifo_len_sel(fifo_len_sel),
      .max_pkt_bytes(max_pkt_bytes), .irq(irq));
   pei_mgmt_model mgmt (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   always #50 pclk = ~pclk;

   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Whole run needs well under a thousand cycles; the ceiling leaves wide margin
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         $display("ERROR cycle_limit expected 0 seen %0d", cycles);
         end_of_test();
      end
   end

   function automatic logic [15:0] exp_stat(input logic [14:0] p, input logic [15:0] m);
      return {m[15] & (|(p & m[14:0])), p & m[14:0]};
   endfunction

   function automatic logic [13:0] exp_len(input logic [1:0] c);
      return (c == 2'b01) ? 14'h2328 : (c == 2'b10) ? 14'h2EE0 : 14'h05EE;
   endfunction

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] e);
      mgmt.rd(a, rd, err);
      `CHK(nm, {16'h0000, e}, rd)
      `CHK("pslverr", 1'b0, err)
   endtask

   task automatic pulse(input logic [14:0] v);
      @(posedge pclk);
      src_evt <= v;
      @(posedge pclk);
      src_evt <= 15'h0000;
      pend = pend | (v & 15'h7FBF);
   endtask

   task automatic irq_chk();
      repeat (2) @(posedge pclk);
      `CHK("irq", mask[15] & (|(pend & mask[14:0])), irq)
   endtask

   task automatic rd_stat();
      rd_chk("status", pei_pkg::ADDR_STAT, exp_stat(pend, mask));
      pend = pend & ~mask[14:0];
      irq_chk();
   endtask

   initial begin
      void'($urandom(32'h0AE3));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk("ctl1", pei_pkg::ADDR_CTL1, 16'h0000);
      rd_chk("ctl2", pei_pkg::ADDR_CTL2, 16'h0000);
      rd_chk("mask", pei_pkg::ADDR_MASK, 16'h0000);
      rd_chk("status", pei_pkg::ADDR_STAT, 16'h0000);
      `CHK("max_pkt_bytes", 14'h05EE, max_pkt_bytes)
      $display("test reset_values done");
      repeat (4) begin
         d = 16'($urandom);
         mgmt.wr(pei_pkg::ADDR_CTL1, d);
         rd_chk("ctl1", pei_pkg::ADDR_CTL1, d & 16'h0008);
         `CHK("far_loop_en", d[3], far_loop_en)
      end
      mgmt.wr_strb(pei_pkg::ADDR_CTL1, ~d, 4'h2);
      rd_chk("ctl1_strb", pei_pkg::ADDR_CTL1, d & 16'h0008);
      $display("test control_one done");
      for (int i = 0; i < 32; i++) begin
         d = 16'($urandom);
         d[15:13] = i[2:0];
         d[5:4] = i[4:3];
         if (d[5:4] != 2'b11) fsel = d[5:4];
         mgmt.wr(pei_pkg::ADDR_CTL2, d);
         rd_chk("ctl2", pei_pkg::ADDR_CTL2, {d[15:13], 7'h00, fsel, 3'h0, d[0]});
         `CHK("edge_rate", d[15:13], edge_rate)
         `CHK("fifo_len_sel", fsel, fifo_len_sel)
         `CHK("max_pkt_bytes", exp_len(fsel), max_pkt_bytes)
         `CHK("cable_loop_en", d[0], cable_loop_en)
      end
      $display("test control_two done");
      mgmt.rd(8'h70, rd, err);
      `CHK("unmapped_err", 1'b1, err)
      `CHK("unmapped_data", 32'h0000_0000, rd)
      d = 16'($urandom);
      mgmt.wr(pei_pkg::ADDR_MASK, d);
      rd_chk("mask", pei_pkg::ADDR_MASK, d & 16'hFFBF);
      mgmt.wr(pei_pkg::ADDR_MASK, 16'h0000);
      $display("test registers done");
      pulse(15'h7FFF);
      irq_chk();
      rd_stat();
      d = 16'($urandom) & 16'h7FBF;
      mgmt.enable_irq(d, rd);
      `CHK("flushed", {16'h0000, exp_stat(pend, d & 16'h7FFF)}, rd)
      pend = pend & ~d[14:0];
      mask = d | 16'h8000;
      rd_stat();
      mask = 16'hFFBF;
      mgmt.wr(pei_pkg::ADDR_MASK, mask);
      irq_chk();
      rd_stat();
      $display("test enable_sequence done");
      repeat (24) begin
         mask = 16'($urandom) & 16'hFFBF;
         mgmt.wr(pei_pkg::ADDR_MASK, mask);
         pulse(15'($urandom));
         irq_chk();
         rd_stat();
      end
      pulse(15'h7FFF);
      d = 16'($urandom);
      mgmt.wr(pei_pkg::ADDR_STAT, d);
      pend = pend & ~(d[14:0] & mask[14:0]);
      rd_stat();
      $display("test random_events done");
      end_of_test();
   end
endmodule // phy_ext_ctrl_interrupt_bench
